/* File: hdl/scgb_pkg.sv */
// constants, types and helpers for the sleep clock gate bank
// Function
// RULE1: each implemented bit enables one unit clock; clear bit stops that unit.
// RULE2: access to a unit whose clock is stopped raises a bus fault.
// RULE3: reset clears the whole register so every unit is unclocked.
// RULE4: register decoded at offset 0x118 from system control base 0x400FE000.
// RULE5: bit 30 is the read-write clock enable of the physical-layer unit.
// RULE6: bit 28 is the read-write clock enable of the media access unit.
// RULE7: bits 6 down to 0 enable ports G down to A.
// RULE8: bits 31, 29 and 27:7 read zero and ignore writes.
// RULE9: software keeps reserved bits unchanged during read-modify-write.
// RULE10: enables apply only in sleep; run and deep sleep use other registers.
// RULE11: sleep gating registers used only when automatic gating select is set.
// RULE12: with automatic gating clear, run enables stay applied while asleep.
package scgb_pkg;

   localparam logic [31:0] SCGB_SYSCTL_BASE  = 32'h400F_E000;
   localparam logic [11:0] SCGB_SLEEP_OFS    = 12'h118;
   localparam logic [31:0] SCGB_RESET_VALUE  = 32'h0000_0000;
   localparam logic [31:0] SCGB_WRITE_MASK   = 32'h5000_007F;
   localparam int          SCGB_PHY_BIT      = 30;
   localparam int          SCGB_MAC_BIT      = 28;
   localparam int          SCGB_PORT_A_BIT   = 0;
   localparam int          SCGB_NUM_PORTS    = 7;
   localparam int          SCGB_NUM_UNITS    = 9;
   localparam int          SCGB_MAC_UNIT     = 7;
   localparam int          SCGB_PHY_UNIT     = 8;
   localparam logic [1:0]  SCGB_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  SCGB_RESP_DECODE  = 2'h3;

   typedef enum logic [1:0] {
      SCGB_ST_IDLE = 2'h1,
      SCGB_ST_ACK  = 2'h2
   } scgb_bus_state_t;

   typedef struct packed {
      logic [11:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } scgb_avs_req_t;

   typedef struct packed {
      logic        sleep_mode;
      logic        deep_sleep_mode;
      logic        auto_sleep_gating_select;
   } scgb_mode_t;

   // register bits to unit enables: ports a..g, mac, phy
   function automatic logic [SCGB_NUM_UNITS-1:0] scgb_units(input logic [31:0] r);
      logic [SCGB_NUM_UNITS-1:0] u;
      u = '0;
      u[SCGB_NUM_PORTS-1:0] = r[SCGB_PORT_A_BIT +: SCGB_NUM_PORTS];
      u[SCGB_MAC_UNIT] = r[SCGB_MAC_BIT];
      u[SCGB_PHY_UNIT] = r[SCGB_PHY_BIT];
      return u;
   endfunction : scgb_units

endpackage : scgb_pkg

/* File: hdl/scgb_unit_gate.sv */
// clock enable selection for one gated unit
`timescale 1ns/100ps
`default_nettype none
module scgb_unit_gate
   import scgb_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic run_en,
   input  wire logic sleep_en,
   input  wire logic deep_en,
   input  wire scgb_mode_t mode,
   output var  logic clock_enable
);

   logic clock_enable_reg;
   logic clock_enable_next;

   always_comb begin
      clock_enable_next = run_en;                                  // RULE10 RULE12
      if (mode.auto_sleep_gating_select) begin                     // RULE11
         if (mode.deep_sleep_mode) begin
            clock_enable_next = deep_en;
         end else if (mode.sleep_mode) begin
            clock_enable_next = sleep_en;                          // RULE1
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clock_enable_reg <= 1'b0;
      end else begin
         clock_enable_reg <= clock_enable_next;
      end
   end

   assign clock_enable = clock_enable_reg;

endmodule : scgb_unit_gate
`default_nettype wire

/* File: hdl/scgb_fault_check.sv */
// bus fault flags for accesses to unclocked units
`timescale 1ns/100ps
`default_nettype none
module scgb_fault_check
   import scgb_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [SCGB_NUM_UNITS-1:0] access_req,
   input  wire logic [SCGB_NUM_UNITS-1:0] clock_enable,
   output var  logic [SCGB_NUM_UNITS-1:0] bus_fault
);

   logic [SCGB_NUM_UNITS-1:0] fault_reg;
   logic [SCGB_NUM_UNITS-1:0] fault_next;

   always_comb begin
      fault_next = access_req & ~clock_enable;                     // RULE2
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_reg <= '0;
      end else begin
         fault_reg <= fault_next;
      end
   end

   assign bus_fault = fault_reg;

   chk_fault_on_gated: assert property ( // RULE2
      @(posedge clk) disable iff (!rst_n)
      (access_req != '0) |=> (bus_fault == ($past(access_req) & ~$past(clock_enable))))
      else $error("bus fault does not match gated access");

endmodule : scgb_fault_check
`default_nettype wire

/* File: hdl/scgb_top.sv */
// sleep clock gate register with avalon slave, unit enables and fault flags
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module scgb_top
   import scgb_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire scgb_avs_req_t             avs_req,
   output var  logic [31:0]               avs_readdata,
   output var  logic                      avs_waitrequest,
   output var  logic [1:0]                avs_response,
   input  wire scgb_mode_t                mode,
   input  wire logic [31:0]               run_clock_gate_two,
   input  wire logic [31:0]               deep_sleep_clock_gate_two,
   input  wire logic [SCGB_NUM_UNITS-1:0] unit_access_req,
   output var  logic [SCGB_NUM_UNITS-1:0] unit_clock_enable,
   output var  logic [SCGB_NUM_UNITS-1:0] unit_bus_fault
);

   scgb_bus_state_t state_reg;
   scgb_bus_state_t state_next;
   logic [31:0]     sleep_clock_gate_two_reg;
   logic [31:0]     sleep_clock_gate_two_next;
   logic [31:0]     readdata_reg;
   logic [31:0]     readdata_next;
   logic [1:0]      response_reg;
   logic [1:0]      response_next;
   logic            waitrequest_reg;
   logic            waitrequest_next;
   logic            hit;
   logic [31:0]     merged;

   logic [SCGB_NUM_UNITS-1:0] run_units;
   logic [SCGB_NUM_UNITS-1:0] sleep_units;
   logic [SCGB_NUM_UNITS-1:0] deep_units;

   // bus slave: one wait cycle, then a single acknowledge cycle
   always_comb begin
      state_next                = state_reg;
      sleep_clock_gate_two_next = sleep_clock_gate_two_reg;
      readdata_next             = readdata_reg;
      response_next             = response_reg;
      waitrequest_next          = 1'b1;
      hit                       = (avs_req.address == SCGB_SLEEP_OFS);   // RULE4
      merged                    = sleep_clock_gate_two_reg;
      for (int b = 0; b < 4; b++) begin
         if (avs_req.byteenable[b]) begin
            merged[8*b +: 8] = avs_req.writedata[8*b +: 8];
         end
      end
      merged = merged & SCGB_WRITE_MASK;                               // RULE8
      case (state_reg)
         SCGB_ST_IDLE: begin
            if (avs_req.read || avs_req.write) begin
               state_next       = SCGB_ST_ACK;
               waitrequest_next = 1'b0;
               response_next    = hit ? SCGB_RESP_OKAY : SCGB_RESP_DECODE;
               readdata_next    = (avs_req.read && hit) ? sleep_clock_gate_two_reg : 32'h0;
            end
         end
         SCGB_ST_ACK: begin
            state_next = SCGB_ST_IDLE;
            if (avs_req.write && hit) begin
               sleep_clock_gate_two_next = merged;                     // RULE5 RULE6 RULE7
            end
         end
         default: begin
            state_next = SCGB_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg                <= SCGB_ST_IDLE;
         sleep_clock_gate_two_reg <= SCGB_RESET_VALUE;                 // RULE3
         readdata_reg             <= 32'h0;
         response_reg             <= SCGB_RESP_OKAY;
         waitrequest_reg          <= 1'b1;
      end else begin
         state_reg                <= state_next;
         sleep_clock_gate_two_reg <= sleep_clock_gate_two_next;
         readdata_reg             <= readdata_next;
         response_reg             <= response_next;
         waitrequest_reg          <= waitrequest_next;
      end
   end

   assign avs_readdata    = readdata_reg;
   assign avs_waitrequest = waitrequest_reg;
   assign avs_response    = response_reg;

   // per-unit clock enable selection
   always_comb begin
      run_units   = scgb_units(run_clock_gate_two);
      sleep_units = scgb_units(sleep_clock_gate_two_reg);
      deep_units  = scgb_units(deep_sleep_clock_gate_two);
   end

   for (genvar u = 0; u < SCGB_NUM_UNITS; u++) begin : g_unit
      scgb_unit_gate u_gate (
         .clk          (clk),
         .rst_n        (rst_n),
         .run_en       (run_units[u]),
         .sleep_en     (sleep_units[u]),
         .deep_en      (deep_units[u]),
         .mode         (mode),
         .clock_enable (unit_clock_enable[u])
      );
   end

   scgb_fault_check u_fault (
      .clk          (clk),
      .rst_n        (rst_n),
      .access_req   (unit_access_req),
      .clock_enable (unit_clock_enable),
      .bus_fault    (unit_bus_fault)
   );

   // checks
   sequence s_write_hit;
      avs_req.write && hit && !waitrequest_reg && (avs_req.byteenable == 4'hF);
   endsequence

   sequence s_read_hit;
      avs_req.read && hit && !waitrequest_reg;
   endsequence

   chk_reset_clears_reg: assert property ( // RULE3
      @(posedge clk) !rst_n |=> (sleep_clock_gate_two_reg == 32'h0) && avs_waitrequest)
      else $error("register not cleared by reset");

   chk_reserved_read_zero: assert property ( // RULE8
      @(posedge clk) disable iff (!rst_n)
      (sleep_clock_gate_two_reg & ~SCGB_WRITE_MASK) == 32'h0)
      else $error("reserved bit became set");

   chk_write_full_word: assert property ( // RULE5
      @(posedge clk) disable iff (!rst_n)
      s_write_hit |=> sleep_clock_gate_two_reg == ($past(avs_req.writedata) & 32'h5000_007F))
      else $error("full word write not stored as masked");

   chk_read_returns_reg: assert property ( // RULE4
      @(posedge clk) disable iff (!rst_n)
      s_read_hit |-> (avs_readdata == sleep_clock_gate_two_reg) && (avs_response == 2'h0))
      else $error("read of gate register returned wrong data");

   chk_unmapped_decode: assert property ( // RULE4
      @(posedge clk) disable iff (!rst_n)
      ((avs_req.read || avs_req.write) && !hit && !avs_waitrequest)
      |-> (avs_response == 2'h3) && (avs_readdata == 32'h0))
      else $error("unmapped access not answered with decode error");

   chk_wait_bounded: assert property (
      @(posedge clk) disable iff (!rst_n)
      (avs_req.read || avs_req.write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
      else $error("request not acknowledged in time");

   chk_sleep_uses_reg: assert property ( // RULE11
      @(posedge clk) disable iff (!rst_n)
      (rst_n && mode.sleep_mode && !mode.deep_sleep_mode && mode.auto_sleep_gating_select)
      |=> unit_clock_enable == scgb_units($past(sleep_clock_gate_two_reg)))
      else $error("sleep enables not taken from gate register");

   chk_auto_clear_run: assert property ( // RULE12
      @(posedge clk) disable iff (!rst_n)
      (rst_n && !mode.auto_sleep_gating_select)
      |=> unit_clock_enable == scgb_units($past(run_clock_gate_two)))
      else $error("run enables not applied with automatic gating clear");

   chk_run_mode_only: assert property ( // RULE10
      @(posedge clk) disable iff (!rst_n)
      (rst_n && !mode.sleep_mode && !mode.deep_sleep_mode)
      |=> unit_clock_enable == scgb_units($past(run_clock_gate_two)))
      else $error("gate register affected run mode");

   chk_phy_bit_map: assert property ( // RULE1
      @(posedge clk) disable iff (!rst_n)
      (rst_n && mode.sleep_mode && !mode.deep_sleep_mode && mode.auto_sleep_gating_select)
      |=> unit_clock_enable[SCGB_PHY_UNIT] == $past(sleep_clock_gate_two_reg[SCGB_PHY_BIT])
          && unit_clock_enable[SCGB_MAC_UNIT] == $past(sleep_clock_gate_two_reg[SCGB_MAC_BIT]))
      else $error("unit enable not tied to its bit");

   // bus handshake checks
   sequence s_request_idle;
      (avs_req.read || avs_req.write) && (state_reg == SCGB_ST_IDLE);
   endsequence

   sequence s_single_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   sequence s_write_top_lane;
      avs_req.write && hit && !waitrequest_reg && (avs_req.byteenable == 4'h8);
   endsequence

   sequence s_gated_access;
      rst_n && ((unit_access_req & ~unit_clock_enable) != '0);
   endsequence

   chk_ack_one_cycle: assert property ( // RULE4
      @(posedge clk) disable iff (!rst_n)
      s_request_idle |=> s_single_ack)
      else $error("acknowledge not a single cycle after one wait");

   chk_state_onehot: assert property (
      @(posedge clk) disable iff (!rst_n)
      $onehot(state_reg))
      else $error("bus state not one-hot");

   chk_ack_state_wait: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state_reg == SCGB_ST_ACK) == !avs_waitrequest)
      else $error("waitrequest does not match acknowledge state");

   chk_readdata_held: assert property (
      @(posedge clk) disable iff (!rst_n)
      !((avs_req.read || avs_req.write) && (state_reg == SCGB_ST_IDLE))
      |=> $stable(avs_readdata) && $stable(avs_response))
      else $error("read data or response changed without a new request");

   chk_write_okay: assert property ( // RULE4
      @(posedge clk) disable iff (!rst_n)
      (avs_req.write && hit && !avs_waitrequest) |-> (avs_response == SCGB_RESP_OKAY))
      else $error("write to gate register not answered okay");

   chk_reserved_read: assert property ( // RULE8
      @(posedge clk) disable iff (!rst_n)
      (avs_req.read && hit && !avs_waitrequest)
      |-> ((avs_readdata & ~SCGB_WRITE_MASK) == 32'h0))
      else $error("reserved bit read back as one");

   chk_bus_reset: assert property ( // RULE3
      @(posedge clk)
      !rst_n |=> (avs_response == SCGB_RESP_OKAY) && (avs_readdata == 32'h0))
      else $error("bus outputs not cleared by reset");

   // register content checks
   chk_write_phy_bit: assert property ( // RULE5
      @(posedge clk) disable iff (!rst_n)
      s_write_hit
      |=> sleep_clock_gate_two_reg[SCGB_PHY_BIT] == $past(avs_req.writedata[SCGB_PHY_BIT]))
      else $error("phy enable bit not stored");

   chk_write_mac_bit: assert property ( // RULE6
      @(posedge clk) disable iff (!rst_n)
      s_write_hit
      |=> sleep_clock_gate_two_reg[SCGB_MAC_BIT] == $past(avs_req.writedata[SCGB_MAC_BIT]))
      else $error("mac enable bit not stored");

   chk_write_port_bits: assert property ( // RULE7
      @(posedge clk) disable iff (!rst_n)
      s_write_hit
      |=> sleep_clock_gate_two_reg[SCGB_PORT_A_BIT +: SCGB_NUM_PORTS]
          == $past(avs_req.writedata[SCGB_PORT_A_BIT +: SCGB_NUM_PORTS]))
      else $error("port enable bits not stored");

   chk_top_lane_merge: assert property ( // RULE8
      @(posedge clk) disable iff (!rst_n)
      s_write_top_lane
      |=> (sleep_clock_gate_two_reg[23:0] == $past(sleep_clock_gate_two_reg[23:0]))
          && (sleep_clock_gate_two_reg[31:24]
              == ($past(avs_req.writedata[31:24]) & SCGB_WRITE_MASK[31:24])))
      else $error("single lane write disturbed other lanes");

   chk_reg_needs_write: assert property ( // RULE8
      @(posedge clk) disable iff (!rst_n)
      !(avs_req.write && hit && !waitrequest_reg) |=> $stable(sleep_clock_gate_two_reg))
      else $error("gate register changed without a write");

   chk_unmapped_write_kept: assert property ( // RULE4
      @(posedge clk) disable iff (!rst_n)
      (avs_req.write && !hit && !waitrequest_reg) |=> $stable(sleep_clock_gate_two_reg))
      else $error("unmapped write changed the gate register");

   // applied enable checks
   chk_enables_reset: assert property ( // RULE3
      @(posedge clk)
      !rst_n |=> (unit_clock_enable == '0) && (unit_bus_fault == '0))
      else $error("unit outputs not cleared by reset");

   chk_deep_uses_deep: assert property ( // RULE10
      @(posedge clk) disable iff (!rst_n)
      (rst_n && mode.deep_sleep_mode && mode.auto_sleep_gating_select)
      |=> unit_clock_enable == scgb_units($past(deep_sleep_clock_gate_two)))
      else $error("deep sleep enables not taken from deep sleep value");

   chk_port_bit_map: assert property ( // RULE7
      @(posedge clk) disable iff (!rst_n)
      (rst_n && mode.sleep_mode && !mode.deep_sleep_mode && mode.auto_sleep_gating_select)
      |=> unit_clock_enable[SCGB_NUM_PORTS-1:0]
          == $past(sleep_clock_gate_two_reg[SCGB_PORT_A_BIT +: SCGB_NUM_PORTS]))
      else $error("port enables not tied to their bits");

   // fault checks
   chk_fault_needs_req: assert property ( // RULE2
      @(posedge clk) disable iff (!rst_n)
      rst_n |=> (unit_bus_fault & ~$past(unit_access_req)) == '0)
      else $error("fault raised without a request");

   chk_no_fault_clocked: assert property ( // RULE1
      @(posedge clk) disable iff (!rst_n)
      (rst_n && ((unit_access_req & unit_clock_enable) != '0))
      |=> (unit_bus_fault & $past(unit_access_req & unit_clock_enable)) == '0)
      else $error("fault raised for a clocked unit");

   chk_fault_one_pulse: assert property ( // RULE2
      @(posedge clk) disable iff (!rst_n)
      s_gated_access ##1 (unit_access_req == '0) |=> unit_bus_fault == '0)
      else $error("fault did not end after the request");

endmodule : scgb_top
`default_nettype wire

/* File: bench/scgb_testbench.sv */
// self-checking testbench for the sleep clock gate bank
`timescale 1ns/100ps
`default_nettype none
module testbench
   import scgb_pkg::*;
();
   logic          clk;
   logic          rst_n;
   scgb_avs_req_t avs_req;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic [1:0]    avs_response;
   scgb_mode_t    mode;
   logic [31:0]   run_gate;
   logic [31:0]   deep_gate;
   logic [8:0]    unit_access_req;
   logic [8:0]    unit_clock_enable;
   logic [8:0]    unit_bus_fault;
   logic [31:0]   rd;
   logic [1:0]    rsp;
   int            bad_count;
   int            comparisons;
   int            cycles;

   scgb_top scgb_top_inst (
      .clk                       (clk),
      .rst_n                     (rst_n),
      .avs_req                   (avs_req),
      .avs_readdata              (avs_readdata),
      .avs_waitrequest           (avs_waitrequest),
      .avs_response              (avs_response),
      .mode                      (mode),
      .run_clock_gate_two        (run_gate),
      .deep_sleep_clock_gate_two (deep_gate),
      .unit_access_req           (unit_access_req),
      .unit_clock_enable         (unit_clock_enable),
      .unit_bus_fault            (unit_bus_fault)
   );

   always #4 clk = ~clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_units(input string what, input logic [8:0] exp, input logic [8:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_units

   // register image to unit order: ports a..g, mac, phy
   function automatic logic [8:0] exp_units(input logic [31:0] r);
      return {r[30], r[28], r[6:0]};
   endfunction : exp_units

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      avs_req <= '{address: addr, read: ~wr, write: wr, writedata: wd, byteenable: be};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rsp = avs_response;
      avs_req <= '0;
      check_word("bus_wait_edges", 32'h0000_0002, n);
   endtask : bus

   task automatic t_reset();
      check_units("enables_after_reset", 9'h000, unit_clock_enable);
      bus(1'b0, 12'h118, 32'h0, 4'h0);
      check_word("reset_value", 32'h0000_0000, rd);
   endtask : t_reset

   task automatic t_fields();
      bus(1'b1, 12'h118, 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, 12'h118, 32'h0, 4'h0);
      check_word("all_ones", 32'h5000_007F, rd);
      check_word("resp_okay", 32'h0, {30'h0, rsp});
      bus(1'b1, 12'h118, 32'h0000_0000, 4'hF);
      bus(1'b1, 12'h118, 32'hFFFF_FFFF, 4'h8);
      bus(1'b0, 12'h118, 32'h0, 4'h0);
      check_word("top_lane_only", 32'h5000_0000, rd);
   endtask : t_fields

   task automatic t_decode();
      bus(1'b1, 12'h108, 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, 12'h108, 32'h0, 4'h0);
      check_word("unmapped_read", 32'h0, rd);
      check_word("unmapped_resp", 32'h3, {30'h0, rsp});
      bus(1'b0, 12'h118, 32'h0, 4'h0);
      check_word("kept_after_unmapped", 32'h5000_0000, rd);
      bus(1'b1, 12'h118, rd | 32'h0000_0004, 4'hF);
      bus(1'b0, 12'h118, 32'h0, 4'h0);
      check_word("read_modify_write", 32'h5000_0004, rd);
   endtask : t_decode

   task automatic t_gating();
      logic [2:0]  sel [5];
      logic [31:0] src [5];
      sel = '{3'b101, 3'b100, 3'b001, 3'b011, 3'b010};
      src = '{32'h4000_0055, 32'h1000_002A, 32'h1000_002A, 32'h5000_0001, 32'h1000_002A};
      bus(1'b1, 12'h118, 32'h4000_0055, 4'hF);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         mode <= '{sleep_mode: sel[i][2], deep_sleep_mode: sel[i][1],
                   auto_sleep_gating_select: sel[i][0]};
         repeat (2) @(posedge clk);
         #1;
         check_units("applied_enables", exp_units(src[i]), unit_clock_enable);
      end
   endtask : t_gating

   task automatic t_fault();
      @(posedge clk);
      mode <= '{sleep_mode: 1'b1, deep_sleep_mode: 1'b0, auto_sleep_gating_select: 1'b1};
      repeat (2) @(posedge clk);
      unit_access_req <= 9'h1FF;
      @(posedge clk);
      unit_access_req <= 9'h000;
      #1;
      check_units("fault_pulse", ~exp_units(32'h4000_0055), unit_bus_fault);
      @(posedge clk);
      #1;
      check_units("fault_ends", 9'h000, unit_bus_fault);
   endtask : t_fault

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      avs_req = '0;
      mode = '0;
      run_gate = 32'h1000_002A;
      deep_gate = 32'h5000_0001;
      unit_access_req = 9'h000;
      bad_count = 0;
      comparisons = 0;
      cycles = 0;
      do_reset();
      t_reset();
      t_fields();
      t_decode();
      t_gating();
      t_fault();
      do_reset();
      t_reset();
      summarize();
   end
endmodule : testbench
`default_nettype wire
